// File: pkg/rrx_pkg.sv
// Constants for the return, rotate and exclusive-OR execution block
package rrx_pkg;

  // Instruction word width and operand widths
  localparam int unsigned INSN_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADR_W = 7;
  localparam int unsigned PC_W   = 13;

  // Opcode patterns
  localparam logic [13:0] RETURN_OP        = 14'h0008;
  localparam logic [5:0]  ROTATE_OP        = 6'h0D;
  localparam logic [5:0]  XOR_FILE_OP      = 6'h06;
  localparam logic [3:0]  RET_LITERAL_OP   = 4'hD;
  localparam logic [5:0]  XOR_LITERAL_OP   = 6'h3A;

  // Field positions
  localparam int unsigned DEST_BIT = 7;

  // Oscillator periods per instruction period
  localparam int unsigned PHASES = 4;

  // Reset values
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [12:0] PC_RST   = 13'h0000;

  // Phase counter states, Gray order
  typedef enum logic [1:0]
  {
    RRX_Q1 = 2'b00,
    RRX_Q2 = 2'b01,
    RRX_Q3 = 2'b11,
    RRX_Q4 = 2'b10
  } rrx_phase_t;

endpackage

// File: hw/rrx_phase_gen.sv
// Four-phase instruction period generator
module rrx_phase_gen
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  output rrx_pkg::rrx_phase_t  phase_o,
  output logic                 cycle_end_o
);

  rrx_pkg::rrx_phase_t phase_q;

  // One instruction period is four oscillator periods
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      phase_q <= rrx_pkg::RRX_Q1;
    else
    begin
      unique case (phase_q)
        rrx_pkg::RRX_Q1: phase_q <= rrx_pkg::RRX_Q2;
        rrx_pkg::RRX_Q2: phase_q <= rrx_pkg::RRX_Q3;
        rrx_pkg::RRX_Q3: phase_q <= rrx_pkg::RRX_Q4;
        rrx_pkg::RRX_Q4: phase_q <= rrx_pkg::RRX_Q1;
      endcase
    end
  end

  assign phase_o     = phase_q;
  assign cycle_end_o = (phase_q == rrx_pkg::RRX_Q4);

endmodule

// File: hw/rrx_exec.sv
// Execution unit for return, rotate and exclusive-OR instructions
// Timing of one instruction period, counted in clock edges from its start:
//   edges 1 to 3  the phase counter walks Q1, Q2, Q3 and nothing commits
//   edge 4        the word on insn_i executes and all state updates
//   after edge 4  the strobes show for exactly one clock
// The word and the file read data must therefore stand through edge 4.
// A return adds a second period in which the word is ignored; only
// nop_cycle_o pulses at its end, so the fetch side can count periods.
//
// Status bits are not stored here. carry_i and zero_i are the live bits,
// and the flag outputs copy them one clock late unless a word updates
// them; whoever owns the status register may take them at any clock.
//
// Limitations: the stack lives outside and stack_pop_o only tells its
// owner to drop the top entry. Words other than the five handled here
// still take a period and raise insn_taken_o, but never strobe a write,
// a pop or a load. The file read is combinational outside, so the path
// from file_addr_o back to file_rdata_i has three clocks to settle.
// Holding insn_i shorter than a full period is not caught here.
module rrx_exec
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Instruction word and the operands read for it
  input  wire logic [13:0] insn_i,
  input  wire logic [12:0] stack_top_entry_i,
  input  wire logic [7:0]  file_rdata_i,
  // Live status bits
  input  wire logic        carry_i,
  input  wire logic        zero_i,
  // File register write port
  output logic [6:0]       file_addr_o,
  output logic [7:0]       file_wdata_o,
  output logic             file_we_o,
  // Accumulator and updated status bits
  output logic [7:0]       acc_o,
  output logic             carry_o,
  output logic             zero_o,
  // Program counter load and stack pop
  output logic [12:0]      pc_o,
  output logic             pc_load_o,
  output logic             stack_pop_o,
  // Period markers for the fetch side
  output logic             insn_taken_o,
  output logic             nop_cycle_o
);

  // Phase counter; only its last phase lets anything commit
  rrx_pkg::rrx_phase_t phase;
  logic                cycle_end;

  rrx_phase_gen u_phase
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .phase_o     (phase),
    .cycle_end_o (cycle_end)
  );

  // Decode
  logic       is_return;
  logic       is_retlit;
  logic       is_rotate;
  logic       is_xor_f;
  logic       is_xor_l;
  logic       dest_file;
  logic [7:0] literal;
  logic [7:0] rot_val;
  logic [7:0] xor_val;
  logic       branch;

  // Full-word match for the plain return; the literal return ignores its
  // two don't-care bits by matching only the top four; the rest use the
  // top six bits; in the file forms bit 7 picks the destination and bits 6:0 the
  // file address. No two of these decodes can be true at once.
  assign is_return = (insn_i == rrx_pkg::RETURN_OP);
  assign is_retlit = (insn_i[13:10] == rrx_pkg::RET_LITERAL_OP);
  assign is_rotate = (insn_i[13:8] == rrx_pkg::ROTATE_OP);
  assign is_xor_f  = (insn_i[13:8] == rrx_pkg::XOR_FILE_OP);
  assign is_xor_l  = (insn_i[13:8] == rrx_pkg::XOR_LITERAL_OP);
  assign dest_file = insn_i[rrx_pkg::DEST_BIT];
  assign literal   = insn_i[7:0];
  assign branch    = is_return | is_retlit;

  // Old carry enters bit 0; old bit 7 leaves as the new carry
  assign rot_val = {file_rdata_i[6:0], carry_i};
  // One XOR serves both forms; only the second operand differs
  assign xor_val = is_xor_l ? (acc_o ^ literal) : (acc_o ^ file_rdata_i);

  // Second period of a branch runs as a no-op; the word is not executed
  logic nop_q;
  logic exec;
  // The one edge per period at which state may change
  assign exec = cycle_end & ~nop_q;

  // Armed by an executed return, cleared by the idle period that follows
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      nop_q <= 1'b0;
    else if (cycle_end)
      nop_q <= exec & branch;
  end

  // One-clock mark of every executed word
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      insn_taken_o <= 1'b0;
    else
      insn_taken_o <= exec;
  end

  // One-clock mark of the idle period after a return
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      nop_cycle_o <= 1'b0;
    else
      nop_cycle_o <= cycle_end & nop_q;
  end

  // Accumulator writes happen once per period, at its last phase.
  // The decodes are exclusive, so the branch order sets no priority.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      acc_o <= rrx_pkg::ACC_RST;
    else if (exec)
    begin
      if (is_retlit)
        acc_o <= literal;
      else if (is_rotate && !dest_file)
        acc_o <= rot_val;
      else if ((is_xor_f && !dest_file) || is_xor_l)
        acc_o <= xor_val;
    end
  end

  // Write strobe only for file-destined rotate and file XOR; with the
  // accumulator as destination the source register is left intact
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      file_we_o <= 1'b0;
    else
      file_we_o <= exec & dest_file & (is_rotate | is_xor_f);
  end

  // Write data is latched on every executed word; only the strobe says
  // that it is meant for the file
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      file_wdata_o <= 8'h00;
    else if (exec)
      file_wdata_o <= is_rotate ? rot_val : xor_val;
  end

  // Address follows the instruction so the file read is combinationally fed
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      file_addr_o <= 7'h00;
    else
      file_addr_o <= insn_i[6:0];
  end

  // Carry changes only on a rotate; otherwise it mirrors the live bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      carry_o <= 1'b0;
    else if (exec && is_rotate)
      carry_o <= file_rdata_i[7];
    else
      carry_o <= carry_i;
  end

  // Zero changes only on an XOR; returns and rotates pass it through
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      zero_o <= 1'b0;
    else if (exec && (is_xor_f || is_xor_l))
      zero_o <= (xor_val == 8'h00);
    else
      zero_o <= zero_i;
  end

  // PC value taken from the stack top on the first period of a return
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pc_o <= rrx_pkg::PC_RST;
    else if (exec && branch)
      pc_o <= stack_top_entry_i;
  end

  // Load and pop strobes stay paired so the stack and PC never disagree
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_load_o   <= 1'b0;
      stack_pop_o <= 1'b0;
    end
    else
    begin
      pc_load_o   <= exec & branch;
      stack_pop_o <= exec & branch;
    end
  end

endmodule

// File: tb/rrx_exec_chk.sv
// Port checker for the execution block
module rrx_exec_chk
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [13:0] insn_i,
  input wire logic [12:0] stack_top_entry_i,
  input wire logic [7:0]  file_rdata_i,
  input wire logic        carry_i,
  input wire logic        zero_i,
  input wire logic [7:0]  acc_o,
  input wire logic        carry_o,
  input wire logic        zero_o,
  input wire logic [12:0] pc_o,
  input wire logic        pc_load_o,
  input wire logic        stack_pop_o,
  input wire logic        file_we_o,
  input wire logic [7:0]  file_wdata_o,
  input wire logic        insn_taken_o,
  input wire logic        nop_cycle_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Pulses show one clock after the edge that took the word, so the word,
  // its operands and the old state are read one sample back
  wire [5:0] op = insn_i[13:8];
  wire       ev = insn_taken_o | nop_cycle_o;
  a_pop_load: assert property
    (pc_load_o == stack_pop_o) else $error("pop without load");
  a_pc_top: assert property
    (pc_load_o |-> pc_o == $past(stack_top_entry_i)) else $error("bad pc");
  a_nop_follow: assert property
    (pc_load_o |-> ##4 nop_cycle_o) else $error("no idle period");
  a_period_four: assert property
    (ev |=> !ev [*3] ##1 ev) else $error("period not four");
  a_xorl_acc: assert property
    (insn_taken_o && $past(op) == 6'h3A
     |-> acc_o == ($past(acc_o) ^ $past(insn_i[7:0])))
    else $error("literal xor");
  a_zero_res: assert property
    (insn_taken_o && $past(op) == 6'h3A |-> zero_o == (acc_o == 8'h00))
    else $error("zero flag");
  a_ret_lit: assert property
    (pc_load_o && $past(insn_i[13:10]) == 4'hD
     |-> acc_o == $past(insn_i[7:0]))
    else $error("literal return");
  a_rot_carry: assert property
    (insn_taken_o && $past(op) == 6'h0D
     |-> carry_o == $past(file_rdata_i[7]))
    else $error("carry");
  a_rot_dest: assert property
    (insn_taken_o && $past(op) == 6'h0D
     |-> file_we_o == $past(insn_i[7])
         && (file_we_o ? file_wdata_o : acc_o)
            == {$past(file_rdata_i[6:0]), $past(carry_i)})
    else $error("rotate destination");
  a_xorf_wr: assert property
    (insn_taken_o && $past(op) == 6'h06 && $past(insn_i[7])
     |-> file_we_o
         && file_wdata_o == ($past(acc_o) ^ $past(file_rdata_i)))
    else $error("file xor write");
  a_xorf_flags: assert property
    (insn_taken_o && $past(op) == 6'h06
     |-> zero_o == (($past(acc_o) ^ $past(file_rdata_i)) == 8'h00)
         && carry_o == $past(carry_i)
         && ($past(insn_i[7])
             || acc_o == ($past(acc_o) ^ $past(file_rdata_i))))
    else $error("file xor result");
  // Main traffic kinds
  c_ret: cover property (pc_load_o ##4 nop_cycle_o);
  c_wr: cover property (file_we_o);
  c_zero: cover property (insn_taken_o && zero_o);
endmodule

// File: tb/rrx_exec_bench.sv
// Directed bench for the execution block
module rrx_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [13:0] insn_i = 14'h0000;
  logic [12:0] stack_top_entry_i = 13'h1ABC;
  logic [7:0]  file_rdata_i = 8'h00;
  logic        carry_i = 1'b0;
  logic        zero_i = 1'b0;
  wire  [6:0]  file_addr_o;
  wire  [7:0]  file_wdata_o, acc_o;
  wire  [12:0] pc_o;
  wire         file_we_o, carry_o, zero_o, pc_load_o, stack_pop_o;
  wire         insn_taken_o, nop_cycle_o;
  int          mismatches = 0;
  int          checks_done = 0;
  always #10 clk_i = ~clk_i;
  rrx_exec DUT
  (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .insn_i            (insn_i),
    .stack_top_entry_i (stack_top_entry_i),
    .file_rdata_i      (file_rdata_i),
    .carry_i           (carry_i),
    .zero_i            (zero_i),
    .file_addr_o       (file_addr_o),
    .file_wdata_o      (file_wdata_o),
    .file_we_o         (file_we_o),
    .acc_o             (acc_o),
    .carry_o           (carry_o),
    .zero_o            (zero_o),
    .pc_o              (pc_o),
    .pc_load_o         (pc_load_o),
    .stack_pop_o       (stack_pop_o),
    .insn_taken_o      (insn_taken_o),
    .nop_cycle_o       (nop_cycle_o)
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Hold a word for one whole period; outputs settle before we look
  task automatic ex(input logic [13:0] w, input logic [7:0] f);
    insn_i = w;
    file_rdata_i = f;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic s_xor;
    ex(14'h3AB5, 8'h00);
    chk(acc_o, 8'hB5);
    ex(14'h3AB5, 8'h00);
    chk(zero_o, 1'b1);
    ex(14'h0620, 8'hAF);
    chk({file_we_o, acc_o, zero_o}, 16'h015E);
    chk(file_addr_o, 7'h20);
    ex(14'h06A0, 8'h1A);
    chk({file_we_o, file_wdata_o, acc_o}, 17'h1B5AF);
  endtask
  task automatic s_rot;
    ex(14'h0D20, 8'hE6);
    chk({file_we_o, acc_o, carry_o}, 16'h0199);
    carry_i = 1'b1;
    ex(14'h0DA0, 8'h66);
    chk({file_we_o, file_wdata_o, carry_o}, 16'h039A);
  endtask
  // Return forms: PC load, pop, flags kept, then an idle period
  task automatic s_ret(input logic [13:0] w, input logic [7:0] a);
    zero_i = 1'b1;
    ex(w, 8'h00);
    chk({pc_load_o, stack_pop_o, carry_o, zero_o}, 16'h000F);
    chk(pc_o, stack_top_entry_i);
    ex(14'h3AFF, 8'h00);
    chk({nop_cycle_o, insn_taken_o, acc_o}, {8'h02, a});
  endtask
  initial
  begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    s_xor();
    s_rot();
    s_ret(14'h0008, 8'hCC);
    stack_top_entry_i = 13'h0123;
    s_ret(14'h3655, 8'h55);
    test_done();
  end
  // Run takes about forty-three clocks; give it ample slack
  initial
  begin
    #5000;
    mismatches++;
    test_done();
  end
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
endmodule
bind rrx_exec rrx_exec_chk u_chk
(
  .clk_i             (clk_i),
  .rst_i             (rst_i),
  .insn_i            (insn_i),
  .stack_top_entry_i (stack_top_entry_i),
  .file_rdata_i      (file_rdata_i),
  .carry_i           (carry_i),
  .zero_i            (zero_i),
  .acc_o             (acc_o),
  .carry_o           (carry_o),
  .zero_o            (zero_o),
  .pc_o              (pc_o),
  .pc_load_o         (pc_load_o),
  .stack_pop_o       (stack_pop_o),
  .file_we_o         (file_we_o),
  .file_wdata_o      (file_wdata_o),
  .insn_taken_o      (insn_taken_o),
  .nop_cycle_o       (nop_cycle_o)
);
